// >>> verilog/dosc_top.sv
`timescale 1ns/100ps
`default_nettype none
module dosc_top (
    // clock and reset
    input  wire logic                                          clock,
    input  wire logic                                          rst,
    // axi4-lite write address
    input  wire logic [7:0]                                    s_axi_awaddr,
    input  wire logic                                          s_axi_awvalid,
    output logic                                               s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0]                                   s_axi_wdata,
    input  wire logic [3:0]                                    s_axi_wstrb,
    input  wire logic                                          s_axi_wvalid,
    output logic                                               s_axi_wready,
    // axi4-lite write response
    output logic [1:0]                                         s_axi_bresp,
    output logic                                               s_axi_bvalid,
    input  wire logic                                          s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]                                    s_axi_araddr,
    input  wire logic                                          s_axi_arvalid,
    output logic                                               s_axi_arready,
    output logic [31:0]                                        s_axi_rdata,
    output logic [1:0]                                         s_axi_rresp,
    output logic                                               s_axi_rvalid,
    input  wire logic                                          s_axi_rready,
    // preamplifier overload lines and cooler limit comparators
    input  wire logic [dosc_pkg::NUM_CH-1:0]                   ovldN,
    input  wire logic [dosc_pkg::NUM_CH-1:0]                   coolerAtLimit,
    // channel outputs
    output dosc_pkg::dosc_chan_out_t [dosc_pkg::NUM_CH-1:0]    chanOut,
    // switch block
    output logic [dosc_pkg::NUM_SW-1:0]                        switchOn,
    output logic [2:0]                                         bankSupply,
    // status
    output logic                                               warning,
    output logic                                               irq
);
    import dosc_pkg::*;

    // register state
    logic              disable_ff;
    logic [NUM_CH-1:0] irqStat_ff;
    logic [NUM_CH-1:0] irqMask_ff;
    logic [NUM_SW-1:0] swEn_ff;
    logic [2:0]        bankSup_ff;
    logic [NUM_CH-1:0] cfgRoute_ff;
    logic [NUM_CH-1:0] cfgExcl_ff;
    logic              cfgBankExcl_ff;
    logic [NUM_SW-1:0] switchOn_ff;
    logic              warning_ff;
    logic              irq_ff;
    logic [NUM_CH-1:0] latchAll;
    logic [NUM_CH-1:0] setEvent;
    logic [NUM_CH-1:0] modeAll;
    logic [3:0]        chCtrlAll [NUM_CH];
    logic [GAIN_W-1:0] gainAll   [NUM_CH];
    logic [COOL_W-1:0] coolVAll  [NUM_CH];
    logic [COOL_W-1:0] coolIAll  [NUM_CH];
    logic              bankTrip;

    // axi state
    logic              awHeld_ff;
    logic              wHeld_ff;
    logic [7:0]        wAddr_ff;
    logic [31:0]       wData_ff;
    logic [3:0]        wStrb_ff;
    logic              bvalid_ff;
    logic [1:0]        bresp_ff;
    logic              rvalid_ff;
    logic [31:0]       rdata_ff;
    logic [1:0]        rresp_ff;
    logic              doWrite;
    dosc_sel_t         wSel;
    dosc_sel_t         rSel;
    logic [1:0]        wCh;
    logic [1:0]        rCh;
    logic [31:0]       rdMux;
    logic [NUM_CH-1:0] clrOvld;
    logic [31:0]       wMask;

    // address decode, low two bits ignored
    function automatic dosc_sel_t decodeSel(input logic [7:0] a);
        dosc_sel_t s;
        logic [7:0] w;
        s = SEL_NONE;
        w = {a[7:2], 2'h0};
        if (w == ADDR_CTRL) begin
            s = SEL_CTRL;
        end else if (w == ADDR_OVLD) begin
            s = SEL_OVLD;
        end else if (w == ADDR_IRQ_STAT) begin
            s = SEL_IRQ_STAT;
        end else if (w == ADDR_IRQ_MASK) begin
            s = SEL_IRQ_MASK;
        end else if (w == ADDR_SWITCH) begin
            s = SEL_SWITCH;
        end else if (w == ADDR_CONFIG) begin
            s = SEL_CONFIG;
        end else if (w == ADDR_STATUS) begin
            s = SEL_STATUS;
        end else if (w[7:4] >= CH_PAGE_FIRST && w[7:4] <= CH_PAGE_LAST) begin
            if (w[3:0] == CH_OFS_CTRL) begin
                s = SEL_CH_CTRL;
            end else if (w[3:0] == CH_OFS_GAIN) begin
                s = SEL_CH_GAIN;
            end else if (w[3:0] == CH_OFS_COOL_V) begin
                s = SEL_CH_COOL_V;
            end else begin
                s = SEL_CH_COOL_I;
            end
        end
        return s;
    endfunction : decodeSel

    // channel index from the page nibble
    function automatic logic [1:0] chIndex(input logic [7:0] a);
        logic [3:0] t;
        t = a[7:4] - CH_PAGE_FIRST;
        return t[1:0];
    endfunction : chIndex

    // byte-lane mask from wstrb; a register bit takes new data only where its lane is strobed
    assign wMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};

    assign wSel = decodeSel(wAddr_ff);
    assign rSel = decodeSel(s_axi_araddr);
    assign wCh  = chIndex(wAddr_ff);
    assign rCh  = chIndex(s_axi_araddr);

    // address and data are taken in either order, held until the write is done
    assign s_axi_awready = !awHeld_ff && !bvalid_ff;
    assign s_axi_wready  = !wHeld_ff && !bvalid_ff;
    assign doWrite       = awHeld_ff && wHeld_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = bresp_ff;

    // write channel capture and response
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            wAddr_ff  <= 8'h00;
            wData_ff  <= 32'h00000000;
            wStrb_ff  <= 4'h0;
            bvalid_ff <= 1'b0;
            bresp_ff  <= RESP_OKAY;
        end else if (doWrite) begin
            awHeld_ff <= 1'b0;
            wHeld_ff  <= 1'b0;
            bvalid_ff <= 1'b1;
            bresp_ff  <= (wSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_ff <= 1'b1;
                wAddr_ff  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_ff <= 1'b1;
                wData_ff <= s_axi_wdata;
                wStrb_ff <= s_axi_wstrb;
            end
            if (bvalid_ff && s_axi_bready) begin
                bvalid_ff <= 1'b0;
            end
        end
    end

    // read mux on the offered address
    always_comb begin
        rdMux = 32'h00000000;
        if (rSel == SEL_CTRL) begin
            rdMux[CTRL_DISABLE_BIT] = disable_ff;
        end else if (rSel == SEL_OVLD) begin
            rdMux[NUM_CH-1:0] = latchAll;
        end else if (rSel == SEL_IRQ_STAT) begin
            rdMux[NUM_CH-1:0] = irqStat_ff;
        end else if (rSel == SEL_IRQ_MASK) begin
            rdMux[NUM_CH-1:0] = irqMask_ff;
        end else if (rSel == SEL_SWITCH) begin
            rdMux[NUM_SW-1:0]               = swEn_ff;
            rdMux[SWITCH_SUP_LSB +: 3]      = bankSup_ff;
        end else if (rSel == SEL_CONFIG) begin
            rdMux[NUM_CH-1:0]               = cfgRoute_ff;
            rdMux[CFG_EXCL_LSB +: NUM_CH]   = cfgExcl_ff;
            rdMux[CFG_BANK_EXCL_BIT]        = cfgBankExcl_ff;
        end else if (rSel == SEL_STATUS) begin
            rdMux[NUM_CH-1:0]               = latchAll;
            rdMux[STAT_MODE_LSB +: NUM_CH]  = modeAll;
            rdMux[STAT_WARN_BIT]            = warning_ff;
            rdMux[STAT_BANK_BIT]            = bankTrip;
        end else if (rSel == SEL_CH_CTRL) begin
            rdMux[3:0] = chCtrlAll[rCh];
        end else if (rSel == SEL_CH_GAIN) begin
            rdMux[GAIN_W-1:0] = gainAll[rCh];
        end else if (rSel == SEL_CH_COOL_V) begin
            rdMux[COOL_W-1:0] = coolVAll[rCh];
        end else if (rSel == SEL_CH_COOL_I) begin
            rdMux[COOL_W-1:0] = coolIAll[rCh];
        end
    end

    // read channel: one cycle to rvalid, held until rready
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h00000000;
            rresp_ff  <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rdMux;
            rresp_ff  <= (rSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid_ff && s_axi_rready) begin
            rvalid_ff <= 1'b0;
        end
    end

    // clear command: ones written to the overload register
    assign clrOvld = (doWrite && wSel == SEL_OVLD && wStrb_ff[0]) ? wData_ff[NUM_CH-1:0] : '0;

    // global control and configuration; all start at zero except the route, which starts with every channel routed
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            disable_ff     <= 1'b0;
            irqMask_ff     <= '0;
            bankSup_ff     <= 3'h0;
            cfgRoute_ff    <= RST_CFG_ROUTE;
            cfgExcl_ff     <= RST_CFG_EXCL;
            cfgBankExcl_ff <= RST_BANK_EXCL;
        end else if (doWrite) begin
            if (wSel == SEL_CTRL) begin
                disable_ff <= (disable_ff & ~wMask[CTRL_DISABLE_BIT])
                              | (wData_ff[CTRL_DISABLE_BIT] & wMask[CTRL_DISABLE_BIT]);
            end else if (wSel == SEL_IRQ_MASK) begin
                irqMask_ff <= (irqMask_ff & ~wMask[NUM_CH-1:0]) | (wData_ff[NUM_CH-1:0] & wMask[NUM_CH-1:0]);
            end else if (wSel == SEL_SWITCH) begin
                bankSup_ff <= (bankSup_ff & ~wMask[SWITCH_SUP_LSB +: 3])
                              | (wData_ff[SWITCH_SUP_LSB +: 3] & wMask[SWITCH_SUP_LSB +: 3]);
            end else if (wSel == SEL_CONFIG) begin
                cfgRoute_ff    <= (cfgRoute_ff & ~wMask[NUM_CH-1:0])
                                  | (wData_ff[NUM_CH-1:0] & wMask[NUM_CH-1:0]);
                cfgExcl_ff     <= (cfgExcl_ff & ~wMask[CFG_EXCL_LSB +: NUM_CH])
                                  | (wData_ff[CFG_EXCL_LSB +: NUM_CH] & wMask[CFG_EXCL_LSB +: NUM_CH]);
                cfgBankExcl_ff <= (cfgBankExcl_ff & ~wMask[CFG_BANK_EXCL_BIT])
                                  | (wData_ff[CFG_BANK_EXCL_BIT] & wMask[CFG_BANK_EXCL_BIT]);
            end
        end
    end

    // bank shutdown from the routed channel latches unless the bank is excluded
    assign bankTrip = (|(latchAll & cfgRoute_ff)) && !cfgBankExcl_ff;

    // switch enables: a trip clears them so they need a fresh write; trip beats a write
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            swEn_ff <= '0;
        end else if (bankTrip) begin
            swEn_ff <= '0;
        end else if (doWrite && wSel == SEL_SWITCH) begin
            swEn_ff <= (swEn_ff & ~wMask[NUM_SW-1:0]) | (wData_ff[NUM_SW-1:0] & wMask[NUM_SW-1:0]);
        end
    end

    // switch outputs: common disable and trip override every enable
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            switchOn_ff <= '0;
        end else if (disable_ff || bankTrip) begin
            switchOn_ff <= '0;
        end else begin
            switchOn_ff <= swEn_ff;
        end
    end

    // sticky event bits, a new event wins over a same-cycle write-one clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            irqStat_ff <= '0;
        end else begin
            irqStat_ff <= setEvent | (irqStat_ff &
                          ~((doWrite && wSel == SEL_IRQ_STAT && wStrb_ff[0]) ? wData_ff[NUM_CH-1:0] : '0));
        end
    end

    // warning and interrupt level, registered
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            warning_ff <= 1'b0;
            irq_ff     <= 1'b0;
        end else begin
            warning_ff <= |latchAll;
            irq_ff     <= |(irqStat_ff & irqMask_ff);
        end
    end

    assign switchOn   = switchOn_ff;
    assign bankSupply = bankSup_ff;
    assign warning    = warning_ff;
    assign irq        = irq_ff;

    // one slice per detector channel
    generate
        for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
            logic              ovldMeta_ff;
            logic              ovldSync_ff;
            logic              limMeta_ff;
            logic              limSync_ff;
            logic              latch_ff;
            logic [3:0]        ctrl_ff;
            logic [GAIN_W-1:0] gain_ff;
            logic [COOL_W-1:0] coolV_ff;
            logic [COOL_W-1:0] coolI_ff;
            dosc_chan_out_t    out_ff;
            logic              chWrite;
            logic              shut;

            // pins are asynchronous; second flop is the only reader of the first
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    ovldMeta_ff <= 1'b1;
                    ovldSync_ff <= 1'b1;
                    limMeta_ff  <= 1'b0;
                    limSync_ff  <= 1'b0;
                end else begin
                    ovldMeta_ff <= ovldN[i];
                    ovldSync_ff <= ovldMeta_ff;
                    limMeta_ff  <= coolerAtLimit[i];
                    limSync_ff  <= limMeta_ff;
                end
            end

            // low level sets the latch; a held-low line defeats the clear
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    latch_ff <= 1'b0;
                end else if (!ovldSync_ff) begin
                    latch_ff <= 1'b1;
                end else if (clrOvld[i]) begin
                    latch_ff <= 1'b0;
                end
            end

            assign setEvent[i] = !ovldSync_ff && !latch_ff;
            assign chWrite     = doWrite && wCh == 2'(i);

            // per-channel settings
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    ctrl_ff  <= 4'h0;
                    gain_ff  <= '0;
                    coolV_ff <= '0;
                    coolI_ff <= '0;
                end else if (chWrite) begin
                    if (wSel == SEL_CH_CTRL) begin
                        ctrl_ff <= (ctrl_ff & ~wMask[3:0]) | (wData_ff[3:0] & wMask[3:0]);
                    end else if (wSel == SEL_CH_GAIN) begin
                        gain_ff <= (gain_ff & ~wMask[GAIN_W-1:0])
                                   | (wData_ff[GAIN_W-1:0] & wMask[GAIN_W-1:0]);
                    end else if (wSel == SEL_CH_COOL_V) begin
                        coolV_ff <= (coolV_ff & ~wMask[COOL_W-1:0])
                                    | (wData_ff[COOL_W-1:0] & wMask[COOL_W-1:0]);
                    end else if (wSel == SEL_CH_COOL_I) begin
                        coolI_ff <= (coolI_ff & ~wMask[COOL_W-1:0])
                                    | (wData_ff[COOL_W-1:0] & wMask[COOL_W-1:0]);
                    end
                end
            end

            // excluded connectors still latch and light, but keep their outputs
            assign shut = latch_ff && !cfgExcl_ff[i];

            // outputs: gain and +12 V fall in the same edge
            always_ff @(posedge clock or posedge rst) begin
                if (rst) begin
                    out_ff <= '0;
                end else begin
                    out_ff.supply12En        <= ctrl_ff[CHC_P12_BIT] && !shut;
                    out_ff.gainCode          <= shut ? '0 : gain_ff;
                    out_ff.supply5En         <= ctrl_ff[CHC_P5_BIT];
                    out_ff.supplyNeg5En      <= ctrl_ff[CHC_N5_BIT];
                    out_ff.coolerEn          <= ctrl_ff[CHC_COOL_BIT];
                    out_ff.coolerVLimit      <= coolV_ff;
                    out_ff.coolerILimit      <= coolI_ff;
                    out_ff.coolerCurrentMode <= ctrl_ff[CHC_COOL_BIT] && limSync_ff;
                    out_ff.ovldLed           <= latch_ff;
                end
            end

            assign chanOut[i]   = out_ff;
            assign latchAll[i]  = latch_ff;
            assign modeAll[i]   = out_ff.coolerCurrentMode;
            assign chCtrlAll[i] = ctrl_ff;
            assign gainAll[i]   = gain_ff;
            assign coolVAll[i]  = coolV_ff;
            assign coolIAll[i]  = coolI_ff;
        end
    endgenerate
endmodule : dosc_top
`default_nettype wire

// >>> verilog/dosc_pkg.sv
package dosc_pkg;
    localparam int NUM_CH = 4;
    localparam int NUM_SW = 8;
    localparam int GAIN_W = 12;
    localparam int COOL_W = 12;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL     = 8'h00;
    localparam logic [7:0] ADDR_OVLD     = 8'h04;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0] ADDR_SWITCH   = 8'h10;
    localparam logic [7:0] ADDR_CONFIG   = 8'h14;
    localparam logic [7:0] ADDR_STATUS   = 8'h18;
    localparam logic [3:0] CH_PAGE_FIRST = 4'h2;
    localparam logic [3:0] CH_PAGE_LAST  = 4'h5;
    localparam logic [3:0] CH_OFS_CTRL   = 4'h0;
    localparam logic [3:0] CH_OFS_GAIN   = 4'h4;
    localparam logic [3:0] CH_OFS_COOL_V = 4'h8;
    localparam logic [3:0] CH_OFS_COOL_I = 4'hC;

    // field positions
    localparam int CTRL_DISABLE_BIT  = 0;
    localparam int SWITCH_SUP_LSB    = 8;
    localparam int CFG_EXCL_LSB      = 4;
    localparam int CFG_BANK_EXCL_BIT = 8;
    localparam int STAT_MODE_LSB     = 4;
    localparam int STAT_WARN_BIT     = 8;
    localparam int STAT_BANK_BIT     = 9;
    localparam int CHC_P12_BIT       = 0;
    localparam int CHC_P5_BIT        = 1;
    localparam int CHC_N5_BIT        = 2;
    localparam int CHC_COOL_BIT      = 3;

    // reset values
    localparam logic [NUM_CH-1:0] RST_CFG_ROUTE = 4'hF;
    localparam logic [NUM_CH-1:0] RST_CFG_EXCL  = 4'h0;
    localparam logic              RST_BANK_EXCL = 1'b0;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum {
        SEL_NONE, SEL_CTRL, SEL_OVLD, SEL_IRQ_STAT, SEL_IRQ_MASK, SEL_SWITCH,
        SEL_CONFIG, SEL_STATUS, SEL_CH_CTRL, SEL_CH_GAIN, SEL_CH_COOL_V, SEL_CH_COOL_I
    } dosc_sel_t;

    typedef struct packed {
        logic              supply12En;
        logic              supply5En;
        logic              supplyNeg5En;
        logic [GAIN_W-1:0] gainCode;
        logic              coolerEn;
        logic [COOL_W-1:0] coolerVLimit;
        logic [COOL_W-1:0] coolerILimit;
        logic              coolerCurrentMode;
        logic              ovldLed;
    } dosc_chan_out_t;
endpackage : dosc_pkg

// >>> tb/dosc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module dosc_chk (
    // clock and reset
    input wire logic                                       clock,
    input wire logic                                       rst,
    // watched pins
    input wire logic                                       s_axi_bvalid,
    input wire logic [dosc_pkg::NUM_CH-1:0]                ovldN,
    input wire logic [dosc_pkg::NUM_CH-1:0]                coolerAtLimit,
    input wire dosc_pkg::dosc_chan_out_t [dosc_pkg::NUM_CH-1:0] chanOut,
    input wire logic [dosc_pkg::NUM_SW-1:0]                switchOn,
    input wire logic                                       warning
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // channel 0 is never excluded by the bench, so its shutdown is checked without config
    ledWarn_a: assert property (chanOut[0].ovldLed |-> warning)
        else $error("indicator lit without warning");
    shutOff_a: assert property (chanOut[0].ovldLed |-> !chanOut[0].supply12En && chanOut[0].gainCode == 12'h0)
        else $error("supply or gain left on under overload");
    ovldSets_a: assert property (!ovldN[0] [*5] |-> chanOut[0].ovldLed)
        else $error("low overload line did not latch");
    syncDelay_a: assert property ($fell(ovldN[0]) && !chanOut[0].ovldLed |=> !chanOut[0].ovldLed [*3])
        else $error("overload taken before synchroniser");
    ledHolds_a: assert property (chanOut[0].ovldLed && !s_axi_bvalid && !$past(s_axi_bvalid)
        |=> chanOut[0].ovldLed)
        else $error("latch dropped without clear");
    swOff_a: assert property ($rose(chanOut[0].ovldLed) |-> switchOn == '0)
        else $error("switches conduct on overload");
    swStay_a: assert property ($rose(|switchOn) |-> s_axi_bvalid || $past(s_axi_bvalid))
        else $error("switch turned on without a write");
    powerOn_a: assert property ($fell(rst) |-> switchOn == '0 && chanOut == '0)
        else $error("output active after reset");
    coolMode_a: assert property (chanOut[0].coolerCurrentMode |-> $past(coolerAtLimit[0], 3))
        else $error("current mode without limit");
endmodule : dosc_chk
bind dosc_top dosc_chk chk_u (.clock, .rst, .s_axi_bvalid, .ovldN, .coolerAtLimit, .chanOut, .switchOn, .warning);
`default_nettype wire

// >>> tb/dosc_preamp.sv
`timescale 1ns/100ps
`default_nettype none
module dosc_preamp (
    // bench commands
    input  wire logic       clock,
    input  wire logic [3:0] ovldReq,
    input  wire logic [3:0] limitReq,
    // lines into the controller
    output logic      [3:0] ovldN = 4'hF,
    output logic      [3:0] coolerAtLimit = 4'h0
);
    // lines move just after the edge, never in step with the sampler
    always @(posedge clock) begin
        ovldN         <= ~ovldReq;
        coolerAtLimit <= limitReq;
    end
endmodule : dosc_preamp
`default_nettype wire

// >>> tb/tb_detector_overload_shutdown_control.sv
`timescale 1ns/100ps
`default_nettype none
module tb_detector_overload_shutdown_control;
    import dosc_pkg::*;
    logic                        clock = 0, rst = 1, awV = 0, wV = 0, arV = 0, warn, irq, awR, wR, bV, arR, rV;
    logic [1:0]                  bResp, rResp;
    logic [7:0]                  awA = 0, arA = 0;
    logic [31:0]                 wD = 0, rD, sw, lfsr = 32'hC5076977, cv [NUM_CH];
    logic [NUM_CH-1:0]           ovReq = 0, limReq = 0, ovldN, atLim;
    logic [NUM_SW-1:0]           swOn;
    logic [2:0]                  bank;
    dosc_chan_out_t [NUM_CH-1:0] co;
    int                          err_total = 0, compares = 0;
    dosc_top dut_u (
        .clock, .rst, .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awR), .s_axi_wdata(wD),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wV), .s_axi_wready(wR), .s_axi_bresp(bResp), .s_axi_bvalid(bV),
        .s_axi_bready(1'b1), .s_axi_araddr(arA), .s_axi_arvalid(arV), .s_axi_arready(arR), .s_axi_rdata(rD),
        .s_axi_rresp(rResp), .s_axi_rvalid(rV), .s_axi_rready(1'b1), .ovldN, .coolerAtLimit(atLim),
        .chanOut(co), .switchOn(swOn), .bankSupply(bank), .warning(warn), .irq
    );
    dosc_preamp model_u (.clock, .ovldReq(ovReq), .limitReq(limReq), .ovldN, .coolerAtLimit(atLim));
    initial begin
        forever #5 clock = ~clock;
    end
    // repeatable register contents
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : nxt
    // channel outputs for a programmed word, shut down or not, indicator lit or not
    function automatic dosc_chan_out_t expCh(input logic [31:0] v, input logic t, input logic l);
        return '{v[0] & !t, v[1], v[2], t ? 12'h0 : v[11:0], v[3], v[23:12], v[31:20], 1'b0, l};
    endfunction : expCh
    task automatic complete_run;
        $display("errors %0d compares %0d", err_total, compares);
        if (err_total == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : complete_run
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %0t got %0h want %0h", $time, got, exp);
        end
    endtask : chk
    // a hung handshake ends the run at once
    task automatic limit(input int n);
        if (n >= 50) begin
            err_total++;
            complete_run();
        end
    endtask : limit
    // write: address and data offered together, each dropped when taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        int n = 0;
        awA <= a;
        wD  <= d;
        awV <= 1'b1;
        wV  <= 1'b1;
        do begin
            @(posedge clock);
            if (awR) awV <= 1'b0;
            if (wR) wV <= 1'b0;
            n++;
        end while (bV !== 1'b1 && n < 50);
        chk(bResp, er);
        limit(n);
        @(posedge clock); // registered outputs settle one edge later
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
        int n = 0;
        arA <= a;
        arV <= 1'b1;
        do begin
            @(posedge clock);
            if (arR) arV <= 1'b0;
            n++;
        end while (rV !== 1'b1 && n < 50);
        chk(rD, e);
        chk(rResp, er);
        limit(n);
    endtask : rd
    initial begin
        repeat (6) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        for (int c = 0; c < NUM_CH; c++) chk(co[c], '0);
        chk(swOn, '0);
        rd(ADDR_CONFIG, 32'h0F, RESP_OKAY);
        rd(8'hFC, '0, RESP_SLVERR);
        for (int c = 0; c < NUM_CH; c++) begin
            lfsr = nxt(lfsr);
            cv[c] = lfsr;
            wr(8'h20 + 8'(c * 16), lfsr, RESP_OKAY);
            wr(8'h24 + 8'(c * 16), lfsr, RESP_OKAY);
            wr(8'h28 + 8'(c * 16), lfsr >> 12, RESP_OKAY);
            wr(8'h2C + 8'(c * 16), lfsr >> 20, RESP_OKAY);
            chk(co[c], expCh(lfsr, 1'b0, 1'b0));
        end
        sw = nxt(lfsr) | 32'h81;
        wr(ADDR_SWITCH, sw, RESP_OKAY);
        chk({bank, swOn}, sw[10:0]);
        wr(ADDR_CTRL, 32'h1, RESP_OKAY);
        chk(swOn, '0);
        wr(ADDR_CTRL, '0, RESP_OKAY);
        chk(swOn, sw[7:0]);
        // overload on channels 0 and 3, channel 3 excluded from shutdown
        wr(ADDR_IRQ_MASK, 32'h1, RESP_OKAY);
        wr(ADDR_CONFIG, 32'h8F, RESP_OKAY);
        ovReq <= 4'h9;
        repeat (8) @(posedge clock);
        chk(co[0], expCh(cv[0], 1'b1, 1'b1));
        chk(co[3], expCh(cv[3], 1'b0, 1'b1));
        chk({warn, irq, swOn}, {2'b11, 8'h0});
        wr(ADDR_OVLD, 32'hF, RESP_OKAY);
        ovReq <= 4'h0;
        repeat (5) @(posedge clock);
        rd(ADDR_OVLD, 32'h9, RESP_OKAY);
        wr(ADDR_OVLD, 32'h9, RESP_OKAY);
        chk(co[0], expCh(cv[0], 1'b0, 1'b0));
        chk(swOn, '0);
        wr(ADDR_IRQ_STAT, 32'h9, RESP_OKAY);
        chk(irq, 1'b0);
        wr(ADDR_SWITCH, sw, RESP_OKAY);
        chk(swOn, sw[7:0]);
        // only channel 0 routed to the bank: channel 3 overload leaves switches alone
        wr(ADDR_CONFIG, 32'h1, RESP_OKAY);
        ovReq <= 4'h8;
        repeat (8) @(posedge clock);
        chk(swOn, sw[7:0]);
        ovReq <= 4'h0;
        repeat (5) @(posedge clock);
        wr(ADDR_OVLD, 32'h8, RESP_OKAY);
        limReq <= 4'hF;
        repeat (6) @(posedge clock);
        for (int c = 0; c < NUM_CH; c++) chk(co[c].coolerCurrentMode, cv[c][3]);
        rd(ADDR_STATUS, {24'h0, cv[3][3], cv[2][3], cv[1][3], cv[0][3], 4'h0}, RESP_OKAY);
        complete_run();
    end
endmodule : tb_detector_overload_shutdown_control
`default_nettype wire
